/* File: core/sfc_cfg.svh */
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// ----------------------------------------------------------------
// Operation codes, sent most significant bit first
// ----------------------------------------------------------------
`define SFC_OP_FAST_READ  8'h0B
`define SFC_OP_SIL_ID     8'hAB
`define SFC_OP_DEV_ID     8'h9F
`define SFC_OP_PAGE_WRITE 8'h02
`define SFC_OP_BULK_ERASE 8'hC7
`define SFC_OP_SECT_ERASE 8'hD8
// The write enable code sits outside this block; the value is a plain default.
`define SFC_OP_WREN       8'h06

// ----------------------------------------------------------------
// Header lengths in bits: code, address, dummy bytes
// ----------------------------------------------------------------
`define SFC_HB_CODE       6'd8
`define SFC_HB_ADDR       6'd32
`define SFC_HB_FAST       6'd40
`define SFC_HB_SIL_ID     6'd32
`define SFC_HB_DEV_ID     6'd24
`define SFC_HDR_W         40

// ----------------------------------------------------------------
// Link timing
// ----------------------------------------------------------------
`define SFC_CLK_NS        8
`define SFC_T_HALF_NS     20
`define SFC_T_CSSU_NS     10
`define SFC_T_CSH_NS      10
`define SFC_T_CSHI_NS     100
`define SFC_CYC(ns)       (((ns) + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_LAST_BIT      3'h7
`define SFC_BITS_PER_BYTE 20'h0_0008

`endif

/* File: core/sfc_host.sv */
`default_nettype none
`include "sfc_cfg.svh"

module sfc_host (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   // Command port
   input  wire logic              cmd_valid,
   input  wire sfc_pkg::sfc_cmd_t cmd,
   output var  logic              cmd_ready,
   // Write data stream
   input  wire logic              wr_valid,
   input  wire logic [7:0]        wr_data,
   output var  logic              wr_ready,
   // Read data stream
   output var  logic              rd_valid,
   output var  logic [7:0]        rd_data,
   // Flash pins
   output var  logic              chip_select_n,
   output var  logic              serial_clock_in,
   output var  logic              serial_cmd_in,
   input  wire logic              serial_data_out
);

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   // Half period from the slowest documented write clock keeps every command legal.
   localparam logic [7:0] HALF_M1 = 8'(`SFC_CYC(`SFC_T_HALF_NS) - 1);
   localparam logic [7:0] SU_M1   = 8'(`SFC_CYC(`SFC_T_CSSU_NS) - 1);
   localparam logic [7:0] HOLD_M1 = 8'(`SFC_CYC(`SFC_T_CSH_NS) - 1);
   localparam logic [7:0] GAP_M1  = 8'(`SFC_CYC(`SFC_T_CSHI_NS) - 1);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   sfc_pkg::sfc_state_t          state_ff;
   sfc_pkg::sfc_kind_t           kind_ff;
   sfc_pkg::sfc_cmd_t            cmd_ff;
   logic [`SFC_HDR_W-1:0]        hdr_ff;
   logic [5:0]                   hdr_left_ff;
   logic [16:0]                  byte_left_ff;
   logic [2:0]                   bit_ff;
   logic [7:0]                   tmr_ff;
   logic [7:0]                   tx_ff;
   logic [7:0]                   rx_ff;
   logic                         loaded_ff;
   logic                         pend_ff;
   logic                         sdo_meta_ff;
   logic                         sdo_sync_ff;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire                 accept_w = (state_ff == sfc_pkg::ST_IDLE) && cmd_ready && cmd_valid;
   wire                 tmr_zero = (tmr_ff == 8'h00);
   wire                 gap_end  = (state_ff == sfc_pkg::ST_GAP) && tmr_zero;
   wire                 load_w   = accept_w || (gap_end && pend_ff);
   wire sfc_pkg::sfc_cmd_t   ld_cmd   = accept_w ? cmd : cmd_ff;
   wire sfc_pkg::sfc_fmt_t   cmd_fmt  = sfc_pkg::sfc_fmt(cmd.kind);
   wire                 ld_pre   = accept_w && cmd_fmt.wren;
   wire sfc_pkg::sfc_kind_t  ld_kind  = ld_pre ? sfc_pkg::K_WREN : ld_cmd.kind;
   wire sfc_pkg::sfc_fmt_t   ld_fmt   = sfc_pkg::sfc_fmt(ld_kind);
   wire sfc_pkg::sfc_fmt_t   fmt      = sfc_pkg::sfc_fmt(kind_ff);
   wire                 in_hdr   = (hdr_left_ff != 6'h00);
   wire                 byte_end = !in_hdr && (bit_ff == `SFC_LAST_BIT);
   wire                 stall_w  = fmt.wr && !in_hdr && (bit_ff == 3'h0) && !loaded_ff;
   wire                 take_w   = stall_w && wr_valid && wr_ready;
   wire                 cur_bit  = in_hdr ? hdr_ff[`SFC_HDR_W-1] : (fmt.wr & tx_ff[7]);
   wire [16:0]          ld_bytes = (ld_fmt.rd || ld_fmt.wr) ? 17'(ld_cmd.nbytes_m1) + 17'h0_0001
                                                            : 17'h0_0000;
   // Frame ends on the eighth bit of the last byte, or after a bare header.
   // bare header: bulk erase or write enable code, sector erase code and address
   wire                 last_w   = (in_hdr && hdr_left_ff == 6'h01 && byte_left_ff == 17'h0_0000)
                                   || (byte_end && byte_left_ff == 17'h0_0001);

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      sdo_meta_ff <= serial_data_out;
      sdo_sync_ff <= sdo_meta_ff;
      rd_valid    <= 1'b0;
      if (!reset_n) begin
         state_ff <= sfc_pkg::ST_IDLE; kind_ff <= sfc_pkg::K_WREN; cmd_ff <= '0;
         hdr_ff <= '0; hdr_left_ff <= '0; byte_left_ff <= '0; bit_ff <= '0;
         tmr_ff <= '0; tx_ff <= '0; rx_ff <= '0; loaded_ff <= 1'b0; pend_ff <= 1'b0;
         cmd_ready <= 1'b0; wr_ready <= 1'b0; rd_data <= '0;
         chip_select_n <= 1'b1; serial_clock_in <= 1'b0; serial_cmd_in <= 1'b0;
      end else if (load_w) begin
         pend_ff      <= ld_pre;
         cmd_ff       <= ld_cmd;
         kind_ff      <= ld_kind;
         hdr_ff       <= {ld_fmt.op, ld_cmd.addr, 8'h00};
         hdr_left_ff  <= ld_fmt.hdr_bits;
         byte_left_ff <= ld_bytes;
         bit_ff       <= 3'h0;
         loaded_ff    <= 1'b0;
         cmd_ready    <= 1'b0;
         chip_select_n <= 1'b0;
         tmr_ff       <= SU_M1;
         state_ff     <= sfc_pkg::ST_SETUP;
      end else begin
         case (state_ff)
            sfc_pkg::ST_IDLE: begin
               cmd_ready <= 1'b1;
            end
            sfc_pkg::ST_SETUP: begin
               tmr_ff <= tmr_zero ? HALF_M1 : tmr_ff - 8'h01;
               if (tmr_zero) begin
                  state_ff <= sfc_pkg::ST_LOW;
               end
            end
            sfc_pkg::ST_LOW: begin
               serial_cmd_in <= cur_bit;
               wr_ready      <= stall_w && !take_w;
               if (take_w) begin
                  tx_ff     <= wr_data;
                  loaded_ff <= 1'b1;
                  tmr_ff    <= HALF_M1;
               end else if (!stall_w && tmr_zero) begin
                  serial_clock_in <= 1'b1;
                  rx_ff    <= {rx_ff[6:0], sdo_sync_ff};
                  tmr_ff   <= HALF_M1;
                  state_ff <= sfc_pkg::ST_HIGH;
               end else if (!stall_w) begin
                  tmr_ff <= tmr_ff - 8'h01;
               end
            end
            sfc_pkg::ST_HIGH: begin
               tmr_ff <= tmr_zero ? (last_w ? HOLD_M1 : HALF_M1) : tmr_ff - 8'h01;
               if (tmr_zero) begin
                  serial_clock_in <= 1'b0;
                  bit_ff          <= bit_ff + 3'h1;
                  hdr_ff          <= in_hdr ? {hdr_ff[`SFC_HDR_W-2:0], 1'b0} : hdr_ff;
                  hdr_left_ff     <= in_hdr ? hdr_left_ff - 6'h01 : hdr_left_ff;
                  tx_ff           <= in_hdr ? tx_ff : {tx_ff[6:0], 1'b0};
                  if (byte_end) begin
                     byte_left_ff <= byte_left_ff - 17'h0_0001;
                     loaded_ff    <= 1'b0;
                     rd_valid     <= fmt.rd;
                     rd_data      <= rx_ff;
                  end
                  state_ff <= last_w ? sfc_pkg::ST_HOLD : sfc_pkg::ST_LOW;
               end
            end
            sfc_pkg::ST_HOLD: begin
               tmr_ff <= tmr_zero ? GAP_M1 : tmr_ff - 8'h01;
               if (tmr_zero) begin
                  chip_select_n <= 1'b1;
                  state_ff      <= sfc_pkg::ST_GAP;
               end
            end
            sfc_pkg::ST_GAP: begin
               tmr_ff <= tmr_zero ? tmr_ff : tmr_ff - 8'h01;
               if (tmr_zero) begin
                  state_ff <= sfc_pkg::ST_IDLE;
               end
            end
            default: begin
               state_ff <= sfc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic        sclk_d_ff;
   logic [19:0] edge_cnt_ff;
   logic [19:0] exp_bits_ff;
   logic [7:0]  obyte_ff;
   logic [16:0] rd_cnt_ff;
   logic        wren_done_ff;

   always_ff @(posedge sys_clk) begin
      sclk_d_ff <= serial_clock_in;
      if (!reset_n || chip_select_n) begin
         edge_cnt_ff <= '0;
         rd_cnt_ff   <= '0;
      end else begin
         edge_cnt_ff <= edge_cnt_ff + 20'((serial_clock_in && !sclk_d_ff));
         rd_cnt_ff   <= rd_cnt_ff + 17'(rd_valid);
      end
      if (serial_clock_in && !sclk_d_ff) begin
         obyte_ff <= {obyte_ff[6:0], serial_cmd_in};
      end
      if (load_w) begin
         exp_bits_ff <= 20'(ld_fmt.hdr_bits) + 20'(ld_bytes) * `SFC_BITS_PER_BYTE;
      end
      if (!reset_n) begin
         wren_done_ff <= 1'b0;
      end else if (state_ff == sfc_pkg::ST_HOLD && tmr_zero) begin
         wren_done_ff <= (kind_ff == sfc_pkg::K_WREN);
      end
   end

   // The count rests at eight until the ninth rise, and the code byte rests with it.
   wire op_seen = (edge_cnt_ff == `SFC_BITS_PER_BYTE);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_fast_read_code: assert property (op_seen && kind_ff == sfc_pkg::K_FAST_READ
      |-> obyte_ff == `SFC_OP_FAST_READ) else $error("fast read code wrong");
   a_sil_id_code: assert property (op_seen && kind_ff == sfc_pkg::K_SIL_ID
      |-> obyte_ff == `SFC_OP_SIL_ID) else $error("silicon id code wrong");
   a_dev_id_code: assert property (op_seen && kind_ff == sfc_pkg::K_DEV_ID
      |-> obyte_ff == `SFC_OP_DEV_ID) else $error("device id code wrong");
   a_bulk_erase_code: assert property (op_seen && kind_ff == sfc_pkg::K_BULK_ERASE
      |-> obyte_ff == `SFC_OP_BULK_ERASE) else $error("bulk erase code wrong");
   a_frame_bit_count: assert property ($rose(chip_select_n)
      |-> $past(edge_cnt_ff) == exp_bits_ff) else $error("frame bit count wrong");
   a_fast_read_header: assert property ($rose(chip_select_n) && kind_ff == sfc_pkg::K_FAST_READ
      |-> $past(edge_cnt_ff) > 20'(`SFC_HB_FAST)) else $error("fast read header short");
   a_wren_before_write: assert property ($fell(chip_select_n) && fmt.wren
      |-> wren_done_ff) else $error("write enable missing");
   a_sector_addr: assert property (($fell(chip_select_n) && kind_ff == sfc_pkg::K_SECT_ERASE)
      |-> ##[1:200] (edge_cnt_ff == 20'(`SFC_HB_ADDR) && chip_select_n == 1'b0))
      else $error("sector erase address missing");
   a_clock_idle_low: assert property (chip_select_n |-> !serial_clock_in)
      else $error("clock high while deselected");
   a_clock_half_time: assert property ($rose(serial_clock_in)
      |-> serial_clock_in[*3]) else $error("clock high phase too short");
   a_id_read_count: assert property ($rose(chip_select_n) && fmt.rd
      |-> $past(rd_cnt_ff) == 17'(cmd_ff.nbytes_m1) + 17'h0_0001) else $error("read count wrong");

   c_fast_read: cover property ($rose(chip_select_n) && kind_ff == sfc_pkg::K_FAST_READ);
   c_page_write: cover property ($rose(chip_select_n) && kind_ff == sfc_pkg::K_PAGE_WRITE);
   c_sector_erase: cover property ($rose(chip_select_n) && kind_ff == sfc_pkg::K_SECT_ERASE);
   c_write_stall: cover property (wr_ready [*3]);

endmodule : sfc_host

`default_nettype wire

/* File: core/sfc_pkg.sv */
`default_nettype none
`include "sfc_cfg.svh"

package sfc_pkg;

   typedef enum logic [2:0] {
      K_FAST_READ, K_SIL_ID, K_DEV_ID, K_PAGE_WRITE, K_BULK_ERASE, K_SECT_ERASE, K_WREN
   } sfc_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_HOLD, ST_GAP
   } sfc_state_t;

   typedef struct packed {
      sfc_kind_t   kind;
      logic [23:0] addr;
      logic [15:0] nbytes_m1;
   } sfc_cmd_t;

   typedef struct packed {
      logic [7:0] op;
      logic [5:0] hdr_bits;
      logic       rd;
      logic       wr;
      logic       wren;
   } sfc_fmt_t;

   function automatic sfc_fmt_t sfc_fmt(input sfc_kind_t k);
      sfc_fmt_t f;
      f = '{op: `SFC_OP_WREN, hdr_bits: `SFC_HB_CODE, rd: 1'b0, wr: 1'b0, wren: 1'b0};
      case (k)
         K_FAST_READ:  f = '{`SFC_OP_FAST_READ, `SFC_HB_FAST, 1'b1, 1'b0, 1'b0};
         K_SIL_ID:     f = '{`SFC_OP_SIL_ID, `SFC_HB_SIL_ID, 1'b1, 1'b0, 1'b0};
         K_DEV_ID:     f = '{`SFC_OP_DEV_ID, `SFC_HB_DEV_ID, 1'b1, 1'b0, 1'b0};
         K_PAGE_WRITE: f = '{`SFC_OP_PAGE_WRITE, `SFC_HB_ADDR, 1'b0, 1'b1, 1'b1};
         K_BULK_ERASE: f = '{`SFC_OP_BULK_ERASE, `SFC_HB_CODE, 1'b0, 1'b0, 1'b1};
         K_SECT_ERASE: f = '{`SFC_OP_SECT_ERASE, `SFC_HB_ADDR, 1'b0, 1'b0, 1'b1};
         default:      f = '{`SFC_OP_WREN, `SFC_HB_CODE, 1'b0, 1'b0, 1'b0};
      endcase
      return f;
   endfunction : sfc_fmt

endpackage : sfc_pkg

`default_nettype wire

/* File: tb/sfc_flash_model.sv */
`default_nettype none
`include "sfc_cfg.svh"

module sfc_flash_model #(
   parameter logic [7:0]  SIL_ID  = 8'h5A,   // Arbitrary value.
   parameter logic [15:0] DEV_ID  = 16'hC396, // Arbitrary value.
   parameter int          SECT_W  = 16,
   parameter int          BUSY_NS = 3000
) (
   // Flash pins
   input  wire logic chip_select_n,
   input  wire logic serial_clock_in,
   input  wire logic serial_cmd_in,
   output var  logic serial_data_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0]  mem [int];
   logic [7:0]  pg [$];
   logic [39:0] sh;
   logic [7:0]  op;
   logic [23:0] ad;
   int          nb;
   logic        wel;
   logic        wip;

   function automatic logic [7:0] rd_mem(input logic [23:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : rd_mem

   initial begin
      serial_data_out = 1'b0;
      wel = 1'b0;
      wip = 1'b0;
      op = 8'h00;
   end

   always @(negedge chip_select_n) begin
      nb = 0;
      pg.delete();
   end

   always @(posedge serial_clock_in) if (!chip_select_n) begin
      sh = {sh[38:0], serial_cmd_in};
      nb++;
      if (nb == 8) op = sh[7:0];
      if (nb == 32) ad = sh[23:0];
      if (op == `SFC_OP_PAGE_WRITE && nb > 32 && nb % 8 == 0) pg.push_back(sh[7:0]);
   end

   always @(negedge serial_clock_in) begin : drive
      int         h;
      int         k;
      logic [7:0] b;
      h = (op == `SFC_OP_FAST_READ) ? 40 : (op == `SFC_OP_SIL_ID) ? 32 :
          (op == `SFC_OP_DEV_ID) ? 24 : 1000;
      k = nb - h;
      // A released or idle line toggles so the host never reads a stale bit.
      if (chip_select_n || wip || k < 0) begin
         serial_data_out = ~serial_data_out;
      end else begin
         b = (op == `SFC_OP_FAST_READ) ? rd_mem(ad + 24'(k / 8)) :
             (op == `SFC_OP_SIL_ID) ? SIL_ID : ((k % 16 < 8) ? DEV_ID[15:8] : DEV_ID[7:0]);
         serial_data_out = b[7 - k % 8];
      end
   end

   always @(posedge chip_select_n) begin : finish
      int          s;
      logic [23:0] a;
      serial_data_out = ~serial_data_out;
      if (op == `SFC_OP_WREN && nb == 8) begin
         wel = 1'b1;
      end else if (wel && !wip && ((op == `SFC_OP_PAGE_WRITE && nb > 32 && nb % 8 == 0) ||
                 (op == `SFC_OP_BULK_ERASE && nb == 8) || (op == `SFC_OP_SECT_ERASE && nb == 32))) begin
         if (op == `SFC_OP_PAGE_WRITE) begin
            s = (pg.size() > 256) ? pg.size() - 256 : 0;
            for (int j = s; j < pg.size(); j++) begin
               a = {ad[23:8], ad[7:0] + 8'(j)};
               mem[a] = rd_mem(a) & pg[j];
            end
         end else if (op == `SFC_OP_BULK_ERASE) begin
            mem.delete();
         end else begin
            foreach (mem[i]) if ((i >> SECT_W) == (int'(ad) >> SECT_W)) mem[i] = 8'hFF;
         end
         wel = 1'b0;
         wip = 1'b1;
         fork
            begin
               #(BUSY_NS);
               wip = 1'b0;
            end
         join_none
      end
   end

endmodule : sfc_flash_model

`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int          BUSY_NS = 3000;
   localparam int          SECT_W  = 16;
   localparam logic [7:0]  SIL_ID  = 8'h5A;   // Arbitrary value.
   localparam logic [15:0] DEV_ID  = 16'hC396; // Arbitrary value.

   logic              sys_clk;
   logic              reset_n;
   logic              cmd_valid;
   sfc_pkg::sfc_cmd_t cmd;
   logic              cmd_ready;
   logic              wr_valid;
   logic [7:0]        wr_data;
   logic              wr_ready;
   logic              rd_valid;
   logic [7:0]        rd_data;
   logic              chip_select_n;
   logic              serial_clock_in;
   logic              serial_cmd_in;
   logic              serial_data_out;
   logic [31:0]       lfsr;
   logic [7:0]        wq [$];
   logic [7:0]        eq [$];
   logic [7:0]        ref_mem [int];
   int                failures;
   int                total_checks;

   sfc_host u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .chip_select_n(chip_select_n),
      .serial_clock_in(serial_clock_in), .serial_cmd_in(serial_cmd_in),
      .serial_data_out(serial_data_out));

   sfc_flash_model #(.SIL_ID(SIL_ID), .DEV_ID(DEV_ID), .SECT_W(SECT_W), .BUSY_NS(BUSY_NS))
      u_flash (.chip_select_n(chip_select_n), .serial_clock_in(serial_clock_in),
      .serial_cmd_in(serial_cmd_in), .serial_data_out(serial_data_out));

   always #4 sys_clk = ~sys_clk;

   function automatic logic [7:0] rnd8();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction : rnd8

   function automatic logic [7:0] ref_rd(input logic [23:0] a);
      return ref_mem.exists(a) ? ref_mem[a] : 8'hFF;
   endfunction : ref_rd

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   task automatic issue(input sfc_pkg::sfc_kind_t k, input logic [23:0] a, input logic [15:0] n);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd       <= '{kind: k, addr: a, nbytes_m1: n};
      do @(posedge sys_clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 40000 && cmd_ready !== 1'b1; i++) @(posedge sys_clk);
      chk("cmd_ready after frame", 1, cmd_ready);
   endtask : issue

   // The flash cycle is not polled, so wait out the model's busy time.
   task automatic busy_wait();
      repeat (BUSY_NS / 8 + 4) @(posedge sys_clk);
   endtask : busy_wait

   task automatic read_chk(input logic [23:0] a, input int n);
      for (int j = 0; j < n; j++) eq.push_back(ref_rd(a + 24'(j)));
      issue(sfc_pkg::K_FAST_READ, a, 16'(n - 1));
      chk("chip_select_n after read", 1, chip_select_n);
      chk("reads pending", 0, eq.size());
   endtask : read_chk

   task automatic page_write(input logic [23:0] a, input int n);
      logic [7:0]  d;
      logic [23:0] p;
      for (int j = 0; j < n; j++) begin
         d = rnd8();
         wq.push_back(d);
         p = {a[23:8], a[7:0] + 8'(j)};
         if (j >= n - 256) ref_mem[p] = ref_rd(p) & d;
      end
      issue(sfc_pkg::K_PAGE_WRITE, a, 16'(n - 1));
      chk("writes pending", 0, wq.size());
      busy_wait();
   endtask : page_write

   // ----------------------------------------------------------------
   // Write stream driver with random stalls
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (wr_valid && wr_ready) begin
         void'(wq.pop_front());
         wr_valid <= 1'b0;
      end else if (!wr_valid && wq.size() > 0 && rnd8() > 8'h60) begin
         wr_valid <= 1'b1;
         wr_data  <= wq[0];
      end
   end

   // ----------------------------------------------------------------
   // Read stream monitor
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (rd_valid === 1'b1) begin
         total_checks++;
         if (eq.size() == 0 || rd_data !== eq[0]) begin
            $display("MISMATCH rd_data expected %h seen %h", eq.size() ? eq[0] : 8'hxx, rd_data);
            failures++;
         end
         if (eq.size() != 0) void'(eq.pop_front());
      end
   end

   initial begin
      #400_000;
      failures++;
      $display("watchdog expired");
      end_sim();
   end

   initial begin
      sys_clk = 1'b0;
      reset_n = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      wr_valid = 1'b0;
      wr_data = 8'h00;
      lfsr = 32'h0000_2246;
      failures = 0;
      total_checks = 0;
      repeat (16) @(posedge sys_clk);
      chk("chip_select_n in reset", 1, chip_select_n);
      reset_n <= 1'b1;
      eq.push_back(SIL_ID);
      eq.push_back(SIL_ID);
      issue(sfc_pkg::K_SIL_ID, 24'h00_0000, 16'h0001);
      $display("test silicon id done");
      eq.push_back(DEV_ID[15:8]);
      eq.push_back(DEV_ID[7:0]);
      issue(sfc_pkg::K_DEV_ID, 24'h00_0000, 16'h0001);
      $display("test device id done");
      issue(sfc_pkg::K_BULK_ERASE, 24'h00_0000, 16'h0000);
      ref_mem.delete();
      busy_wait();
      page_write(24'hFF_FFFC, 6);
      page_write(24'h00_0010, 2);
      page_write(24'h00_0200, 258);
      read_chk(24'hFF_FFFC, 6);
      read_chk(24'hFF_FF00, 2);
      read_chk(24'h00_000F, 4);
      read_chk(24'h00_0200, 3);
      $display("test page write done");
      issue(sfc_pkg::K_SECT_ERASE, 24'hFF_1234, 16'h0000);
      foreach (ref_mem[i]) if ((i >> SECT_W) == 32'h0000_00FF) ref_mem[i] = 8'hFF;
      busy_wait();
      read_chk(24'hFF_FFFC, 4);
      read_chk(24'h00_000F, 4);
      $display("test sector erase done");
      end_sim();
   end

endmodule : tb_top

`default_nettype wire
